// file: logic/rdc_defines.vh
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH

// Register byte offsets
`define RDC_SEL_OFS      12'h770
`define RDC_DATA_OFS     12'h774
`define RDC_SEL_RST      16'h0000

// Configuration RAM geometry
`define RDC_DEPTH        768
`define RDC_AW           10

// Select register fields
`define RDC_S_CH_LO      0
`define RDC_S_WS_LO      8
`define RDC_S_DIR        14
`define RDC_S_BUSY       15

// Word select codes
`define RDC_WS_HOSTWR    3'h4
`define RDC_WS_LAST      3'h5

// Dword 2 fields
`define RDC_F_ON         0
`define RDC_F_POL_LO     1
`define RDC_F_OFS_LO     3
`define RDC_F_THR_LO     7
`define RDC_F_FBF        15
`define RDC_F_BC_LO      16
`define RDC_F_TC_LO      29

// Buffer size policies
`define RDC_POL_LARGE    2'h0
`define RDC_POL_SMALL    2'h1
`define RDC_POL_MIXED    2'h2

// Masks for writes into a dword
`define RDC_MASK_ALL     32'hffffffff
`define RDC_MASK_HOSTLO  32'h0000ffff
`define RDC_MASK_HOSTHI  32'hffff0000
`define RDC_MASK_DMA_DW2 32'hfffffc00
`define RDC_MASK_NONE    32'h00000000

`define RDC_BC_MAX       13'h1fff

// DMA request opcodes
`define RDC_OP_RD        2'h0
`define RDC_OP_WR        2'h1
`define RDC_OP_EVT       2'h2

`endif

// file: logic/rdc_cfg_ram.v
`timescale 1ns/10ps
`include "rdc_defines.vh"

module rdc_cfg_ram (
    // Clock
    input  wire                clk_i,
    // Access port
    input  wire                en_i,
    input  wire                we_i,
    input  wire [`RDC_AW-1:0]  addr_i,
    input  wire [31:0]         wmask_i,
    input  wire [31:0]         wdata_i,
    output reg  [31:0]         rdata_o
);

    // Contents are not reset; the host programs every channel it uses
    reg [31:0] mem [0:`RDC_DEPTH-1];

    always @(posedge clk_i) begin
        if (en_i) begin
            if (we_i) begin
                mem[addr_i] <= (mem[addr_i] & ~wmask_i) |
                               (wdata_i & wmask_i);
            end
            rdata_o <= mem[addr_i];
        end
    end

endmodule

// file: logic/rdc_fill_track.v
`timescale 1ns/10ps
`include "rdc_defines.vh"

module rdc_fill_track (
    // Current dword 2 and receive events
    input  wire [31:0] cur_i,
    input  wire [12:0] bytes_i,
    input  wire        buf_done_i,
    input  wire        pkt_start_i,
    input  wire        pkt_end_i,
    // Updated dword 2 and decisions
    output reg  [31:0] nxt_o,
    output reg         dq_wr_o,
    output reg         small_o,
    output reg  [3:0]  start_ofs_o
);

    reg [2:0]  thr;
    reg [2:0]  tc;
    reg [13:0] sum;
    reg [12:0] bc;
    reg        fbf;
    reg [1:0]  pol;

    always @* begin
        thr     = cur_i[`RDC_F_THR_LO+2:`RDC_F_THR_LO];
        pol     = cur_i[`RDC_F_POL_LO+1:`RDC_F_POL_LO];
        tc      = cur_i[`RDC_F_TC_LO+2:`RDC_F_TC_LO];
        fbf     = cur_i[`RDC_F_FBF];
        dq_wr_o = 1'b0;
        sum     = {1'b0, cur_i[`RDC_F_BC_LO+12:`RDC_F_BC_LO]} +
                  {1'b0, bytes_i};
        // Saturate rather than wrap so a runaway buffer stays visible
        bc      = sum[13] ? `RDC_BC_MAX : sum[12:0];
        if (pkt_start_i) begin
            fbf = 1'b1;
            tc  = 3'h0;
            bc  = 13'h0000;
        end
        if (buf_done_i) begin
            bc  = 13'h0000;
            fbf = 1'b0;
            tc  = tc + 3'h1;
            if (thr != 3'h0 && tc == thr) begin
                dq_wr_o = 1'b1;
                tc      = 3'h0;
            end
        end
        if (pkt_end_i) begin
            // Packet completion always reports, threshold or not
            dq_wr_o = 1'b1;
            tc      = 3'h0;
            bc      = 13'h0000;
            fbf     = 1'b1;
        end
        nxt_o = cur_i;
        nxt_o[`RDC_F_BC_LO+12:`RDC_F_BC_LO] = bc;
        nxt_o[`RDC_F_TC_LO+2:`RDC_F_TC_LO]  = tc;
        nxt_o[`RDC_F_FBF]                   = fbf;
        // Policy 11 is illegal; it falls back to large buffers
        small_o = (pol == `RDC_POL_SMALL) ||
                  (pol == `RDC_POL_MIXED && fbf);
        start_ofs_o = fbf ? cur_i[`RDC_F_OFS_LO+3:`RDC_F_OFS_LO]
                          : 4'h0;
    end

endmodule

// file: logic/rdc_rx_dma_cfg.v
// Behaviour
// - dword 0 holds current buffer address, host reads
// - dword 1 low half: current descriptor pointer
// - dword 1 high half: starting descriptor pointer
// - dword 2 bit 0 enables the channel
// - two-bit buffer size policy, 11 illegal
// - first buffer data offset 0 to 15 bytes
// - threshold picks when done queue is written
// - first buffer flag set while filling first buffer
// - 13-bit byte count up to 8191
// - threshold count of filled buffers, 0 to 7
// - host writes only word select 100
// - eight-bit channel select, 00h is channel 1
// - word select 000 to 101, 110/111 illegal
// - direction one reads word, busy until ready
// - direction zero writes data, busy until done
// - data register returns read or supplies write
// - select register resets zero, busy read-only
// - 256 channels of three dwords, 768 total
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "rdc_defines.vh"

module rdc_rx_dma_cfg (
    // Clock and reset
    input  wire        clk_i,
    input  wire        srst_i,
    // Register port
    input  wire [11:0] reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // DMA request port
    input  wire        dma_req_i,
    input  wire [1:0]  dma_op_i,
    input  wire [7:0]  dma_chan_i,
    input  wire [1:0]  dma_dword_i,
    input  wire [31:0] dma_wdata_i,
    input  wire [12:0] dma_bytes_i,
    input  wire        dma_buf_done_i,
    input  wire        dma_pkt_start_i,
    input  wire        dma_pkt_end_i,
    // DMA answer port
    output reg         dma_busy_o,
    output reg         dma_ack_o,
    output reg  [31:0] dma_rdata_o,
    output reg         dma_dq_wr_o,
    output reg         dma_chan_off_o,
    output reg         dma_small_buf_o,
    output reg  [3:0]  dma_data_ofs_o
);

    localparam [1:0] H_IDLE = 2'h0;
    localparam [1:0] H_PEND = 2'h1;
    localparam [1:0] H_RWT  = 2'h2;

    localparam [1:0] D_IDLE = 2'h0;
    localparam [1:0] D_WAIT = 2'h1;

    // Channel entry base is chan * 3
    function [`RDC_AW-1:0] rdc_index;
        input [7:0] chan;
        input [1:0] dw;
        begin
            rdc_index = ({2'b00, chan} << 1) + {2'b00, chan} +
                        {8'h00, dw};
        end
    endfunction

    // Select register image as the host reads it back
    function [15:0] rdc_sel_word;
        input       busy;
        input       dir;
        input [2:0] ws;
        input [7:0] chan;
        begin
            rdc_sel_word = {busy, dir, 3'h0, ws, chan};
        end
    endfunction

    // Codes 110 and 111 name no word; they must never reach the RAM
    function rdc_ws_ok;
        input [2:0] ws;
        begin
            rdc_ws_ok = (ws <= `RDC_WS_LAST);
        end
    endfunction

    // Odd word selects name the upper half of a dword
    function [15:0] rdc_half;
        input [31:0] dword;
        input        upper;
        begin
            rdc_half = upper ? dword[31:16] : dword[15:0];
        end
    endfunction

    // Host indirect registers
    reg [7:0]  chan_sel_r;
    reg [2:0]  word_sel_r;
    reg        dir_r;
    reg        busy_r;
    reg [15:0] data_r;
    reg [1:0]  h_st_r;
    reg [1:0]  h_st_nxt;

    // DMA sequencer registers
    reg [1:0]  d_st_r;
    reg [1:0]  d_op_r;
    reg [7:0]  d_chan_r;
    reg [12:0] d_bytes_r;
    reg        d_bdone_r;
    reg        d_pstart_r;
    reg        d_pend_r;

    // RAM port
    reg                ram_en;
    reg                ram_we;
    reg [`RDC_AW-1:0]  ram_addr;
    reg [31:0]         ram_wmask;
    reg [31:0]         ram_wdata;
    wire [31:0]        ram_q;

    wire [31:0] trk_nxt;
    wire        trk_dq;
    wire        trk_small;
    wire [3:0]  trk_ofs;

    wire sel_hit  = (reg_addr_i == `RDC_SEL_OFS);
    wire data_hit = (reg_addr_i == `RDC_DATA_OFS);
    wire d_take   = dma_req_i && (d_st_r == D_IDLE);
    wire d_evt_wb = (d_st_r == D_WAIT) && (d_op_r == `RDC_OP_EVT);
    wire d_use    = d_take || d_evt_wb;
    wire ws_legal = rdc_ws_ok(word_sel_r);
    wire h_go     = (h_st_r == H_PEND) && !d_use;

    rdc_cfg_ram u_ram (
        .clk_i   (clk_i),
        .en_i    (ram_en),
        .we_i    (ram_we),
        .addr_i  (ram_addr),
        .wmask_i (ram_wmask),
        .wdata_i (ram_wdata),
        .rdata_o (ram_q)
    );

    rdc_fill_track u_trk (
        .cur_i       (ram_q),
        .bytes_i     (d_bytes_r),
        .buf_done_i  (d_bdone_r),
        .pkt_start_i (d_pstart_r),
        .pkt_end_i   (d_pend_r),
        .nxt_o       (trk_nxt),
        .dq_wr_o     (trk_dq),
        .small_o     (trk_small),
        .start_ofs_o (trk_ofs)
    );

    // RAM arbitration: the DMA always wins, the host only waits
    always @* begin
        ram_en    = 1'b0;
        ram_we    = 1'b0;
        ram_addr  = {`RDC_AW{1'b0}};
        ram_wmask = `RDC_MASK_NONE;
        ram_wdata = 32'h00000000;
        if (d_evt_wb) begin
            ram_en    = ram_q[`RDC_F_ON];
            ram_we    = 1'b1;
            ram_addr  = rdc_index(d_chan_r, 2'h2);
            // Host fields in bits 0 to 9 are never touched here
            ram_wmask = `RDC_MASK_DMA_DW2;
            ram_wdata = trk_nxt;
        end else if (d_take) begin
            ram_en   = 1'b1;
            ram_addr = (dma_op_i == `RDC_OP_EVT) ?
                       rdc_index(dma_chan_i, 2'h2) :
                       rdc_index(dma_chan_i, dma_dword_i);
            if (dma_op_i == `RDC_OP_WR) begin
                ram_we    = 1'b1;
                ram_wdata = dma_wdata_i;
                case (dma_dword_i)
                    2'h0:    ram_wmask = `RDC_MASK_ALL;
                    2'h1:    ram_wmask = `RDC_MASK_ALL;
                    2'h2:    ram_wmask = `RDC_MASK_DMA_DW2;
                    default: ram_wmask = `RDC_MASK_NONE;
                endcase
            end
        end else if (h_go && ws_legal) begin
            ram_en   = 1'b1;
            ram_addr = rdc_index(chan_sel_r, word_sel_r[2:1]);
            if (!dir_r && word_sel_r == `RDC_WS_HOSTWR) begin
                ram_we    = 1'b1;
                ram_wmask = `RDC_MASK_HOSTLO;
                ram_wdata = {16'h0000, data_r};
            end
        end
    end

    // Host indirect access sequencer
    // A pending access waits for any cycle in which the DMA leaves
    // the RAM port alone; a read then needs one more cycle for the
    // registered RAM output before the data register is loaded.
    // Busy therefore lasts at least two cycles for a legal read and one
    // for a write or an illegal read, longer under heavy DMA traffic.
    always @* begin
        h_st_nxt = h_st_r;
        case (h_st_r)
            H_IDLE: begin
                if (reg_wr_i && sel_hit) begin
                    h_st_nxt = H_PEND;
                end
            end
            H_PEND: begin
                if (h_go) begin
                    h_st_nxt = (dir_r && ws_legal) ? H_RWT : H_IDLE;
                end
            end
            H_RWT: begin
                h_st_nxt = H_IDLE;
            end
            default: begin
                h_st_nxt = H_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            h_st_r     <= H_IDLE;
            chan_sel_r <= 8'h00;
            word_sel_r <= 3'h0;
            dir_r      <= 1'b0;
            busy_r     <= 1'b0;
            data_r     <= 16'h0000;
        end else begin
            h_st_r <= h_st_nxt;
            // Writes while busy are dropped to protect the access
            if (reg_wr_i && sel_hit && !busy_r) begin
                chan_sel_r <= reg_wdata_i[`RDC_S_CH_LO+7:`RDC_S_CH_LO];
                word_sel_r <= reg_wdata_i[`RDC_S_WS_LO+2:`RDC_S_WS_LO];
                dir_r      <= reg_wdata_i[`RDC_S_DIR];
                busy_r     <= 1'b1;
            end else if (h_st_r == H_PEND && h_go &&
                         !(dir_r && ws_legal)) begin
                busy_r <= 1'b0;
                if (dir_r) begin
                    data_r <= 16'h0000;
                end
            end else if (h_st_r == H_RWT) begin
                data_r <= rdc_half(ram_q, word_sel_r[0]);
                busy_r <= 1'b0;
            end
            if (reg_wr_i && data_hit && !busy_r) begin
                data_r <= reg_wdata_i[15:0];
            end
        end
    end

    // Register read path, data one cycle after the strobe
    always @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i && sel_hit) begin
            reg_rdata_o <= {16'h0000,
                            rdc_sel_word(busy_r, dir_r, word_sel_r,
                                         chan_sel_r)};
        end else if (reg_rd_i && data_hit) begin
            reg_rdata_o <= {16'h0000, data_r};
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

    // DMA sequencer
    always @(posedge clk_i) begin
        if (srst_i) begin
            d_st_r          <= D_IDLE;
            d_op_r          <= `RDC_OP_RD;
            d_chan_r        <= 8'h00;
            d_bytes_r       <= 13'h0000;
            d_bdone_r       <= 1'b0;
            d_pstart_r      <= 1'b0;
            d_pend_r        <= 1'b0;
            dma_busy_o      <= 1'b0;
            dma_ack_o       <= 1'b0;
            dma_rdata_o     <= 32'h00000000;
            dma_dq_wr_o     <= 1'b0;
            dma_chan_off_o  <= 1'b0;
            dma_small_buf_o <= 1'b0;
            dma_data_ofs_o  <= 4'h0;
        end else begin
            dma_ack_o   <= 1'b0;
            dma_dq_wr_o <= 1'b0;
            case (d_st_r)
                D_IDLE: begin
                    if (dma_req_i) begin
                        d_st_r     <= D_WAIT;
                        d_op_r     <= dma_op_i;
                        d_chan_r   <= dma_chan_i;
                        d_bytes_r  <= dma_bytes_i;
                        d_bdone_r  <= dma_buf_done_i;
                        d_pstart_r <= dma_pkt_start_i;
                        d_pend_r   <= dma_pkt_end_i;
                        dma_busy_o <= 1'b1;
                    end
                end
                D_WAIT: begin
                    d_st_r      <= D_IDLE;
                    dma_busy_o  <= 1'b0;
                    dma_ack_o   <= 1'b1;
                    dma_rdata_o <= ram_q;
                    if (d_op_r == `RDC_OP_EVT) begin
                        // Disabled channel: events leave state as is
                        dma_chan_off_o  <= !ram_q[`RDC_F_ON];
                        dma_dq_wr_o     <= trk_dq &&
                                           ram_q[`RDC_F_ON];
                        dma_small_buf_o <= trk_small;
                        dma_data_ofs_o  <= trk_ofs;
                    end
                end
                default: begin
                    d_st_r     <= D_IDLE;
                    dma_busy_o <= 1'b0;
                end
            endcase
        end
    end

endmodule

// file: bench/rdc_props.sv
`timescale 1ns/10ps
module rdc_props (
    // Clock and reset
    input wire        clk_i,
    input wire        srst_i,
    // Register port
    input wire        reg_rd_i,
    input wire [31:0] reg_rdata_o,
    // DMA port
    input wire        dma_req_i,
    input wire        dma_busy_o,
    input wire        dma_ack_o,
    input wire        dma_dq_wr_o,
    input wire        dma_chan_off_o,
    input wire        dma_small_buf_o,
    input wire [3:0]  dma_data_ofs_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence taken_s;
        dma_req_i && !dma_busy_o;
    endsequence
    sequence answer_s;
        dma_busy_o ##1 (dma_ack_o && !dma_busy_o);
    endsequence

    dma_walk_a: assert property (taken_s |=> answer_s)
        else $error("dma answer not on second edge");
    busy_pulse_a: assert property (dma_busy_o |=> !dma_busy_o)
        else $error("dma busy longer than one cycle");
    ack_cause_a: assert property (
        dma_ack_o |-> $past(dma_req_i && !dma_busy_o, 2))
        else $error("ack without taken request");
    ack_pulse_a: assert property (dma_ack_o |=> !dma_ack_o)
        else $error("ack longer than one cycle");
    dq_with_ack_a: assert property (dma_dq_wr_o |-> dma_ack_o)
        else $error("done queue write outside ack");
    off_no_dq_a: assert property (
        dma_ack_o && dma_chan_off_o |-> !dma_dq_wr_o)
        else $error("done queue write on disabled channel");
    ofs_hold_a: assert property (!dma_ack_o |-> $stable(dma_data_ofs_o))
        else $error("offset changed without ack");
    small_hold_a: assert property (
        !dma_ack_o |-> $stable(dma_small_buf_o))
        else $error("buffer size changed without ack");
    rdata_idle_a: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read answer");
endmodule

bind rdc_rx_dma_cfg rdc_props u_props (
    .clk_i          (clk_i),
    .srst_i         (srst_i),
    .reg_rd_i       (reg_rd_i),
    .reg_rdata_o    (reg_rdata_o),
    .dma_req_i      (dma_req_i),
    .dma_busy_o     (dma_busy_o),
    .dma_ack_o      (dma_ack_o),
    .dma_dq_wr_o    (dma_dq_wr_o),
    .dma_chan_off_o (dma_chan_off_o),
    .dma_small_buf_o(dma_small_buf_o),
    .dma_data_ofs_o (dma_data_ofs_o)
);

// file: bench/tb_rdc_rx_dma_cfg.sv
`timescale 1ns/10ps
module tb_rdc_rx_dma_cfg;
    reg         clk_i = 0;
    reg         srst_i = 1;
    reg  [11:0] ra = 0;
    reg  [31:0] rw = 0;
    reg         wr = 0;
    reg         rd = 0;
    reg         req = 0;
    reg  [1:0]  op = 0;
    reg  [7:0]  ch = 0;
    reg  [1:0]  dw = 0;
    reg  [31:0] dwd = 0;
    reg  [12:0] nb = 0;
    reg         bd = 0, ps = 0, pe = 0;
    wire [31:0] rq, drd;
    wire        busy, ack, dq, off, sm;
    wire [3:0]  ofs;
    reg  [31:0] m [0:767];
    integer     n_checks, bad_count;

    rdc_rx_dma_cfg dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(ra), .reg_wdata_i(rw),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rq), .dma_req_i(req),
        .dma_op_i(op), .dma_chan_i(ch), .dma_dword_i(dw), .dma_wdata_i(dwd),
        .dma_bytes_i(nb), .dma_buf_done_i(bd), .dma_pkt_start_i(ps),
        .dma_pkt_end_i(pe), .dma_busy_o(busy), .dma_ack_o(ack),
        .dma_rdata_o(drd), .dma_dq_wr_o(dq), .dma_chan_off_o(off),
        .dma_small_buf_o(sm), .dma_data_ofs_o(ofs)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task print_verdict;
        begin
            $display("checks %0d bad %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask

    task rwr(input [11:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            ra <= a;
            rw <= {16'h0, d};
            wr <= 1'b1;
            @(posedge clk_i);
            wr <= 1'b0;
        end
    endtask

    task rrd(input [11:0] a, output [31:0] d);
        begin
            @(posedge clk_i);
            ra <= a;
            rd <= 1'b1;
            @(posedge clk_i);
            rd <= 1'b0;
            @(negedge clk_i);
            d = rq;
        end
    endtask

    // Indirect access, then poll busy and fetch the data register
    task hacc(input dir, input [2:0] ws, input [7:0] c, output [31:0] d);
        reg [31:0] s;
        integer    i;
        begin
            rwr(12'h770, {1'b0, dir, 3'h0, ws, c});
            i = 0;
            s = 32'h8000;
            while (s[15] !== 1'b0 && i < 20) begin
                rrd(12'h770, s);
                i = i + 1;
            end
            chk("sel", {17'h0, dir, 3'h0, ws, c}, s);
            rrd(12'h774, d);
        end
    endtask

    task dacc(input [1:0] o, input [7:0] c, input [1:0] w,
              input [31:0] d, input [12:0] b, input [2:0] e);
        integer i;
        begin
            @(posedge clk_i);
            req <= 1'b1;
            op <= o;
            ch <= c;
            dw <= w;
            dwd <= d;
            nb <= b;
            {bd, ps, pe} <= e;
            @(posedge clk_i);
            req <= 1'b0;
            i = 0;
            while (ack !== 1'b1 && i < 8) begin
                @(negedge clk_i);
                i = i + 1;
            end
            chk("ack", 1, ack);
        end
    endtask

    // Event model: e = {buf_done, pkt_start, pkt_end}
    task ev(input [7:0] c, input [12:0] b, input [2:0] e);
        reg [31:0] o, n;
        reg        q;
        integer    bc, tc;
        begin
            o = m[c*3+2];
            n = o;
            q = 0;
            if (o[0]) begin
                bc = o[28:16] + b;
                if (bc > 8191)
                    bc = 8191;
                tc = o[31:29];
                if (e[1]) begin
                    n[15] = 1;
                    bc = 0;
                    tc = 0;
                end
                if (e[2]) begin
                    bc = 0;
                    n[15] = 0;
                    tc = (tc + 1) & 7;
                    if (tc == o[9:7] && tc != 0) begin
                        q = 1;
                        tc = 0;
                    end
                end
                if (e[0]) begin
                    q = 1;
                    bc = 0;
                    tc = 0;
                    n[15] = 1;
                end
                n[28:16] = bc;
                n[31:29] = tc;
            end
            dacc(2'h2, c, 0, 0, b, e);
            chk("old_dw2", o, drd);
            chk("dq", q, dq);
            chk("off", !o[0], off);
            if (o[0]) begin
                chk("small", o[2:1] == 1 || (o[2:1] == 2 && n[15]), sm);
                chk("ofs", n[15] ? o[6:3] : 0, ofs);
            end
            m[c*3+2] = n;
        end
    endtask

    initial begin
        #(100 * 20000);
        bad_count = bad_count + 1;
        print_verdict;
    end

    initial begin : main
        integer    k, w, p;
        reg [31:0] d, x, e;
        reg [7:0]  c;
        reg [7:0]  cl [0:2];
        reg [2:0]  evs [0:5];
        n_checks = 0;
        bad_count = 0;
        void'($urandom(49));
        cl = '{8'h00, 8'hff, 8'h00};
        cl[2] = $urandom;
        evs = '{3'b010, 3'b000, 3'b100, 3'b100, 3'b100, 3'b001};
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        rrd(12'h770, d);
        chk("sel_rst", 0, d);
        rrd(12'h774, d);
        chk("dat_rst", 0, d);
        rrd(12'h7fc, d);
        chk("unmapped", 0, d);
        for (k = 0; k < 3; k = k + 1) begin
            c = cl[k];
            for (w = 0; w < 3; w = w + 1) begin
                x = $urandom;
                dacc(1, c, w, x, 0, 0);
                m[c*3+w] = x;
            end
            x = $urandom & 32'h3ff;
            rwr(12'h774, x);
            hacc(0, 4, c, d);
            chk("wdat", x, d);
            m[c*3+2][15:0] = x;
            x = $urandom;
            dacc(1, c, 2, x, 0, 0);
            m[c*3+2][31:10] = x[31:10];
            hacc(0, 0, c, d);
            for (w = 0; w < 8; w = w + 1) begin
                hacc(1, w, c, d);
                e = w > 5 ? 0 : m[c*3+w/2] >> (16 * (w % 2));
                chk("hrd", e & 32'hffff, d);
            end
            for (w = 0; w < 3; w = w + 1) begin
                dacc(0, c, w, 0, 0, 0);
                chk("drd", m[c*3+w], drd);
            end
        end
        for (p = 0; p < 3; p = p + 1) begin
            x = 1 | p << 1 | ($urandom & 15) << 3 | (p * 3) << 7;
            rwr(12'h774, x);
            hacc(0, 4, 8'h07, d);
            dacc(1, 8'h07, 2, 0, 0, 0);
            m[23] = x;
            for (k = 0; k < 6; k = k + 1)
                ev(8'h07, $urandom & 8191, evs[k]);
        end
        rwr(12'h774, 0);
        hacc(0, 4, 8'h07, d);
        m[23][15:0] = 0;
        ev(8'h07, 5, 3'b100);
        print_verdict;
    end
endmodule
